// File: hw/pwm_tb_cfg.svh
// Constants for the PWM time-base interrupt and duty-match block
// Operation
// - Single-shot mode raises an event when counter equals period.
// - Single-shot match clears counter next edge and clears the run bit.
// - Single-shot mode ignores the postscaler; every match gives an event.
// - Up/down mode raises an event when counter hits zero turning upward.
// - Up/down mode signals only every Nth zero event via postscaler.
// - Four 14-bit duty values: six high-byte bits plus eight low bits.
// - Duty values are double-buffered; compare copy updates separately.
// - Each output stays active for a time set by its duty value.
// - Upper twelve duty bits compare with counter low twelve bits.
// - Lowest two duty bits pick the quarter phase at 1:1 prescale.
// - Edge-aligned active period starts at first quarter phase, ends on match.
// - At 1:1, match needs counter equality and matching quarter phase.
// - Override logic; complementary mode makes pair outputs complementary.
`ifndef PWM_TB_CFG_SVH
`define PWM_TB_CFG_SVH
`define OFS_CTRL 8'h00
`define OFS_PERIOD 8'h04
`define OFS_COUNTER 8'h08
`define OFS_DUTY0 8'h10
`define OFS_STATUS 8'h20
`define OFS_IRQEN 8'h24
`define OFS_IRQCLR 8'h28
`define OFS_OVR 8'h2c
// Control field positions
`define CTRL_RUN 0
`define CTRL_MODE_LO 1
`define CTRL_PS_LO 3
`define CTRL_POST_LO 5
`define CTRL_COMP 9
`define CTRL_UPD 10
`define MODE_FREE 2'h0
`define MODE_SINGLE 2'h1
`define MODE_UPDOWN 2'h2
`define PS_ONE 2'h0
`define RST_PERIOD 12'hfff
`endif

// File: hw/pwm_tb_pkg.sv
// Types for the PWM time-base interrupt and duty-match block
`default_nettype none
package pwm_tb_pkg;
    typedef enum logic [1:0] {PH1, PH2, PH3, PH4} phase_t;
    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } avReq_t;
    typedef struct packed {
        logic [3:0] hi;
        logic [3:0] lo;
    } pwmPins_t;
endpackage
`default_nettype wire

// File: hw/pwm_timebase_irq_duty_match.sv
// PWM time base with interrupt events, duty match and output override
`include "pwm_tb_cfg.svh"
`default_nettype none
module pwm_timebase_irq_duty_match (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [7:0] avAddress,
    input wire logic avRead,
    input wire logic avWrite,
    input wire logic [31:0] avWriteData,
    output logic [31:0] avReadData,
    output logic avWaitRequest,
    // Power stage and interrupt
    output logic [3:0] pwmHi,
    output logic [3:0] pwmLo,
    output logic irq
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [13:0] dutyJoin(input logic [7:0] hiB,
                                             input logic [7:0] loB);
        dutyJoin = {hiB[5:0], loB};
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pwm_tb_pkg::avReq_t req;
    logic [10:0] ctrl_r, ctrl_nxt;
    logic [11:0] period_r, period_nxt;
    logic [11:0] timebaseCounter_r, timebaseCounter_nxt;
    logic countDown_r, countDown_nxt;
    logic [1:0] psCnt_r, psCnt_nxt;
    logic [3:0] postCnt_r, postCnt_nxt;
    pwm_tb_pkg::phase_t phase_r, phase_nxt;
    logic [13:0] dutyHold_r [4];
    logic [13:0] dutyHold_nxt [4];
    logic [13:0] dutyAct_r [4];
    logic [13:0] dutyAct_nxt [4];
    logic [7:0] ovr_r, ovr_nxt;
    logic [1:0] status_r, status_nxt;
    logic [1:0] irqEn_r, irqEn_nxt;
    logic [3:0] active_r, active_nxt;
    logic [3:0] pwmHi_nxt, pwmLo_nxt;
    logic irq_nxt;
    logic [31:0] rdata_nxt;
    logic ack_r, ack_nxt;
    logic tbEvent, dutyUpd, tick, periodStart;
    logic [3:0] match;
    logic wrAck;

    assign req = '{address: avAddress, read: avRead, write: avWrite,
                   writedata: avWriteData};
    // One wait cycle then the answer: waitrequest drops for one edge.
    assign avWaitRequest = ~ack_r;
    assign wrAck = req.write & ack_r;

    // ------------------------------------------------------------
    // Bus slave and registers
    // ------------------------------------------------------------
    always_comb begin
        ctrl_nxt = ctrl_r;
        period_nxt = period_r;
        ovr_nxt = ovr_r;
        irqEn_nxt = irqEn_r;
        dutyHold_nxt = dutyHold_r;
        ack_nxt = (req.read | req.write) & ~ack_r;
        rdata_nxt = 32'h0;
        if (wrAck) begin
            case (req.address)
                `OFS_CTRL: ctrl_nxt = req.writedata[10:0];
                `OFS_PERIOD: period_nxt = req.writedata[11:0];
                `OFS_IRQEN: irqEn_nxt = req.writedata[1:0];
                `OFS_OVR: ovr_nxt = req.writedata[7:0];
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (req.address == `OFS_DUTY0 + 8'(4 * i)) begin
                            dutyHold_nxt[i] = dutyJoin(req.writedata[15:8],
                                                       req.writedata[7:0]);
                        end
                    end
                end
            endcase
        end
        if (tbEvent && ctrl_r[`CTRL_MODE_LO+:2] == `MODE_SINGLE) begin
            ctrl_nxt[`CTRL_RUN] = 1'b0;
        end
        if (req.read & ~ack_r) begin
            case (req.address)
                `OFS_CTRL: rdata_nxt = {21'h0, ctrl_r};
                `OFS_PERIOD: rdata_nxt = {20'h0, period_r};
                `OFS_COUNTER: rdata_nxt = {20'h0, timebaseCounter_r};
                `OFS_STATUS: rdata_nxt = {30'h0, status_r};
                `OFS_IRQEN: rdata_nxt = {30'h0, irqEn_r};
                `OFS_OVR: rdata_nxt = {24'h0, ovr_r};
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (req.address == `OFS_DUTY0 + 8'(4 * i)) begin
                            rdata_nxt = {18'h0, dutyHold_r[i]};
                        end
                    end
                end
            endcase
        end else if (ack_r) begin
            rdata_nxt = avReadData;
        end
    end

    // ------------------------------------------------------------
    // Time base and events
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] mode;
        mode = ctrl_r[`CTRL_MODE_LO+:2];
        phase_nxt = pwm_tb_pkg::phase_t'(2'(phase_r + 2'h1));
        psCnt_nxt = psCnt_r;
        timebaseCounter_nxt = timebaseCounter_r;
        countDown_nxt = countDown_r;
        postCnt_nxt = postCnt_r;
        tbEvent = 1'b0;
        // Counter steps at end of instruction cycle, divided by prescale
        tick = 1'b0;
        if (ctrl_r[`CTRL_RUN] && phase_r == pwm_tb_pkg::PH4) begin
            psCnt_nxt = 2'(psCnt_r + 2'h1);
            case (ctrl_r[`CTRL_PS_LO+:2])
                2'h0: tick = 1'b1;
                2'h1: tick = psCnt_r[0];
                default: tick = psCnt_r == 2'h3;
            endcase
            if (tick) begin
                psCnt_nxt = 2'h0;
            end
        end
        if (tick) begin
            case (mode)
                `MODE_SINGLE: begin
                    if (timebaseCounter_r == period_r) begin
                        tbEvent = 1'b1;
                        timebaseCounter_nxt = 12'h0;
                    end else begin
                        timebaseCounter_nxt = 12'(timebaseCounter_r + 12'h1);
                    end
                end
                `MODE_UPDOWN: begin
                    if (countDown_r) begin
                        if (timebaseCounter_r == 12'h1 ||
                            timebaseCounter_r == 12'h0) begin
                            timebaseCounter_nxt = 12'h0;
                            countDown_nxt = 1'b0;
                            if (postCnt_r == ctrl_r[`CTRL_POST_LO+:4]) begin
                                postCnt_nxt = 4'h0;
                                tbEvent = 1'b1;
                            end else begin
                                postCnt_nxt = 4'(postCnt_r + 4'h1);
                            end
                        end else begin
                            timebaseCounter_nxt = 12'(timebaseCounter_r - 12'h1);
                        end
                    end else if (timebaseCounter_r >= period_r) begin
                        countDown_nxt = 1'b1;
                        timebaseCounter_nxt = 12'(timebaseCounter_r - 12'h1);
                    end else begin
                        timebaseCounter_nxt = 12'(timebaseCounter_r + 12'h1);
                    end
                end
                default: begin
                    timebaseCounter_nxt = timebaseCounter_r == period_r ?
                        12'h0 : 12'(timebaseCounter_r + 12'h1);
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Duty match and outputs
    // ------------------------------------------------------------
    always_comb begin
        logic onePs;
        onePs = ctrl_r[`CTRL_PS_LO+:2] == `PS_ONE;
        periodStart = ctrl_r[`CTRL_RUN] && phase_r == pwm_tb_pkg::PH1 &&
                      timebaseCounter_r == 12'h0;
        dutyUpd = periodStart & ctrl_r[`CTRL_UPD];
        dutyAct_nxt = dutyAct_r;
        active_nxt = active_r;
        for (int i = 0; i < 4; i++) begin
            match[i] = dutyAct_r[i][13:2] == timebaseCounter_r;
            if (onePs) begin
                match[i] = match[i] && phase_r == dutyAct_r[i][1:0];
            end else begin
                match[i] = match[i] && phase_r == pwm_tb_pkg::PH1;
            end
            if (dutyUpd) begin
                dutyAct_nxt[i] = dutyHold_r[i];
            end
            if (match[i]) begin
                active_nxt[i] = 1'b0;
            end else if (periodStart) begin
                active_nxt[i] = 1'b1;
            end
            pwmHi_nxt[i] = ovr_r[i + 4] ? ovr_r[i] : active_r[i];
            pwmLo_nxt[i] = ctrl_r[`CTRL_COMP] ? ~pwmHi_nxt[i] :
                           (ovr_r[i + 4] ? ~ovr_r[i] : active_r[i]);
        end
        // Set wins over a same-cycle clear
        status_nxt = {1'b0, tbEvent} | (status_r & ~(wrAck &&
            req.address == `OFS_IRQCLR ? req.writedata[1:0] : 2'h0));
        if (|match) begin
            status_nxt[1] = 1'b1;
        end
        irq_nxt = |(status_nxt & irqEn_nxt);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= 11'h0;
            period_r <= `RST_PERIOD;
            ovr_r <= 8'h0;
            irqEn_r <= 2'h0;
            status_r <= 2'h0;
            ack_r <= 1'b0;
            avReadData <= 32'h0;
            timebaseCounter_r <= 12'h0;
            countDown_r <= 1'b0;
            psCnt_r <= 2'h0;
            postCnt_r <= 4'h0;
            phase_r <= pwm_tb_pkg::PH1;
            active_r <= 4'h0;
            pwmHi <= 4'h0;
            pwmLo <= 4'h0;
            irq <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                dutyHold_r[i] <= 14'h0;
                dutyAct_r[i] <= 14'h0;
            end
        end else begin
            ctrl_r <= ctrl_nxt;
            period_r <= period_nxt;
            ovr_r <= ovr_nxt;
            irqEn_r <= irqEn_nxt;
            status_r <= status_nxt;
            ack_r <= ack_nxt;
            avReadData <= rdata_nxt;
            timebaseCounter_r <= timebaseCounter_nxt;
            countDown_r <= countDown_nxt;
            psCnt_r <= psCnt_nxt;
            postCnt_r <= postCnt_nxt;
            phase_r <= phase_nxt;
            active_r <= active_nxt;
            pwmHi <= pwmHi_nxt;
            pwmLo <= pwmLo_nxt;
            irq <= irq_nxt;
            dutyHold_r <= dutyHold_nxt;
            dutyAct_r <= dutyAct_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence singleMatch;
        tick && ctrl_r[2:1] == `MODE_SINGLE && timebaseCounter_r == period_r;
    endsequence

    AST_SINGLE_EVENT: assert property (@(posedge clk_sys) disable iff (!nrst)
        singleMatch |=> status_r[0]) else $error("single-shot event lost");
    AST_SINGLE_CLEAR: assert property (@(posedge clk_sys) disable iff (!nrst)
        singleMatch |=> timebaseCounter_r == 12'h0 && !ctrl_r[0])
        else $error("single-shot clear missing");
    AST_SINGLE_NOPOST: assert property (@(posedge clk_sys) disable iff (!nrst)
        singleMatch |-> tbEvent) else $error("postscaler applied");
    AST_UPDOWN_EVENT: assert property (@(posedge clk_sys) disable iff (!nrst)
        tbEvent && ctrl_r[2:1] == `MODE_UPDOWN |=> timebaseCounter_r == 12'h0
        && !countDown_r) else $error("zero event misplaced");
    AST_POSTSCALE: assert property (@(posedge clk_sys) disable iff (!nrst)
        tbEvent && ctrl_r[2:1] == `MODE_UPDOWN |-> postCnt_r == ctrl_r[8:5])
        else $error("postscale count wrong");
    AST_DUTY_BUFFER: assert property (@(posedge clk_sys) disable iff (!nrst)
        !dutyUpd |=> dutyAct_r[0] == $past(dutyAct_r[0]))
        else $error("compare copy changed");
    AST_PHASE_MATCH: assert property (@(posedge clk_sys) disable iff (!nrst)
        match[0] && ctrl_r[4:3] == `PS_ONE |-> phase_r == dutyAct_r[0][1:0])
        else $error("phase mismatch");
    AST_PS_Q1: assert property (@(posedge clk_sys) disable iff (!nrst)
        match[0] && ctrl_r[4:3] != `PS_ONE |-> phase_r == pwm_tb_pkg::PH1)
        else $error("prescaled match off first phase");
    AST_ACTIVE_END: assert property (@(posedge clk_sys) disable iff (!nrst)
        match[0] |=> !active_r[0] ##1
        pwmHi[0] == ($past(ovr_r[4]) ? $past(ovr_r[0]) : 1'b0))
        else $error("output not ended by match");
    AST_COMPLEMENT: assert property (@(posedge clk_sys) disable iff (!nrst)
        ctrl_r[9] |=> pwmLo == ~pwmHi) else $error("pair not complementary");

    // ------------------------------------------------------------
    // Checks on buffering, compare and bus timing
    // ------------------------------------------------------------
    sequence dutyWrite0;
        wrAck && req.address == `OFS_DUTY0;
    endsequence

    sequence periodOpen;
        periodStart && !match[0];
    endsequence

    AST_DUTY_JOIN: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        dutyWrite0 |=> dutyHold_r[0] == $past(req.writedata[13:0]))
        else $error("duty halves joined wrongly");
    AST_HOLD_KEEP: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        !(wrAck && req.address == `OFS_DUTY0) |=>
        dutyHold_r[0] == $past(dutyHold_r[0]))
        else $error("holding copy changed without a write");
    AST_DUTY_LOAD: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        dutyUpd |=> dutyAct_r[0] == $past(dutyHold_r[0]))
        else $error("compare copy not loaded");
    AST_COMPARE_BITS: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        match[0] |-> dutyAct_r[0][13:2] == timebaseCounter_r)
        else $error("match without counter equality");
    AST_PHASE_STEP: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        phase_r == pwm_tb_pkg::PH4 |=> phase_r == pwm_tb_pkg::PH1)
        else $error("quarter phase did not wrap");
    AST_START_Q1: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        $rose(active_r[0]) |-> $past(periodStart))
        else $error("active period began off the first phase");
    AST_ACTIVE_HIGH: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        periodOpen |=> active_r[0])
        else $error("output not raised at period start");
    AST_UPDOWN_TURN: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        tick && ctrl_r[2:1] == `MODE_UPDOWN && !countDown_r &&
        timebaseCounter_r >= period_r |=> countDown_r)
        else $error("up/down count did not turn at period");
    AST_FREE_WRAP: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        tick && ctrl_r[2:1] == `MODE_FREE && timebaseCounter_r == period_r
        |=> timebaseCounter_r == 12'h0)
        else $error("edge-aligned period did not wrap");
    AST_PS_HALF: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        ctrl_r[4:3] == 2'h1 && !psCnt_r[0] |-> !tick)
        else $error("half-rate prescale stepped early");
    AST_OVERRIDE: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        ovr_r[4] |=> pwmHi[0] == $past(ovr_r[0]))
        else $error("override value not driven");
    AST_IRQ_LEVEL: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        irq == |(status_r & irqEn_r))
        else $error("interrupt level disagrees with status");
    AST_STATUS_STICKY: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        status_r[0] && !(wrAck && req.address == `OFS_IRQCLR &&
        req.writedata[0]) |=> status_r[0])
        else $error("event bit dropped without a clear");
    AST_WAIT_ONE: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (avRead || avWrite) && avWaitRequest |=> !avWaitRequest)
        else $error("bus answer late");
    AST_WAIT_BACK: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        !avWaitRequest |=> avWaitRequest)
        else $error("wait request low for more than one cycle");
endmodule // pwm_timebase_irq_duty_match
`default_nettype wire

// File: test/power_stage_model.sv
// Behavioural half-bridge driver stage watching the pair outputs
`default_nettype none
module power_stage_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Gate drive from the block
    input wire logic [3:0] pwmHi,
    input wire logic [3:0] pwmLo,
    // Count of cycles with both switches of a leg on
    output logic [7:0] shootCount
);
    logic [7:0] shootCount_nxt;
    // ----------------------------------------
    // Shoot-through monitor
    // ----------------------------------------
    // both switches of any leg on
    always_comb begin
        shootCount_nxt = shootCount;
        if (|(pwmHi & pwmLo)) begin
            shootCount_nxt = shootCount + 8'h01;
        end
    end
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            shootCount <= 8'h00;
        end else begin
            shootCount <= shootCount_nxt;
        end
    end
endmodule // power_stage_model
`default_nettype wire

// File: test/pwm_timebase_irq_duty_match_bench.sv
// Register-level bench for the PWM time base and duty match block
`include "pwm_tb_cfg.svh"
`default_nettype none
module pwm_timebase_irq_duty_match_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, nrst, avRead, avWrite, avWaitRequest, irq;
    logic [7:0] avAddress, shootCount, s0;
    logic [31:0] avWriteData, avReadData, rd;
    logic [3:0] pwmHi, pwmLo;
    int fail_count, checked, d1, d2, wa, wb, wc;
    int w[2][4];
    time t0;
    pwm_timebase_irq_duty_match pwm_timebase_irq_duty_match_i (
        .clk_sys(clk_sys), .nrst(nrst), .avAddress(avAddress),
        .avRead(avRead), .avWrite(avWrite), .avWriteData(avWriteData),
        .avReadData(avReadData), .avWaitRequest(avWaitRequest),
        .pwmHi(pwmHi), .pwmLo(pwmLo), .irq(irq));
    power_stage_model power_stage_model_i (.clk_sys(clk_sys), .nrst(nrst),
        .pwmHi(pwmHi), .pwmLo(pwmLo), .shootCount(shootCount));
    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until the edge that samples waitrequest low
    task automatic busDo(input logic wr, input logic [7:0] a,
                         input logic [31:0] d);
        @(posedge clk_sys);
        avAddress <= a;
        avWriteData <= d;
        avWrite <= wr;
        avRead <= !wr;
        do begin
            @(posedge clk_sys);
        end while (avWaitRequest !== 1'b0);
        rd = avReadData;
        avWrite <= 1'b0;
        avRead <= 1'b0;
    endtask
    task automatic busWrite(input logic [7:0] a, input logic [31:0] d);
        busDo(1'b1, a, d);
    endtask
    task automatic busRead(input logic [7:0] a);
        busDo(1'b0, a, 32'h0);
    endtask
    task automatic waitSig(input bit useIrq, input logic v);
        int n = 0;
        while (((useIrq ? irq : pwmHi[0]) !== v) && n < 600) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 600) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, !v, v);
        end
    endtask
    task automatic clearEvents();
        busWrite(`OFS_IRQCLR, 32'h3);
        waitSig(1'b1, 1'b0);
    endtask
    // Skips pulses that may still carry the previous compare copy
    task automatic measure(output int wd);
        repeat (2) begin
            waitSig(1'b0, 1'b1);
            waitSig(1'b0, 1'b0);
        end
        waitSig(1'b0, 1'b1);
        wd = 0;
        while (pwmHi[0] === 1'b1 && wd < 600) begin
            @(posedge clk_sys);
            wd++;
        end
    endtask
    task automatic irqSpacing(output int d);
        waitSig(1'b1, 1'b1);
        clearEvents();
        waitSig(1'b1, 1'b1);
        t0 = $time;
        clearEvents();
        waitSig(1'b1, 1'b1);
        d = int'(($time - t0) / 10);
    endtask
    function automatic logic [31:0] ctrlWord(input logic [1:0] m,
        input logic [1:0] ps, input logic [3:0] post, input logic comp,
        input logic upd);
        return 32'h1 | (32'(m) << `CTRL_MODE_LO) | (32'(ps) << `CTRL_PS_LO)
            | (32'(post) << `CTRL_POST_LO) | (32'(comp) << `CTRL_COMP)
            | (32'(upd) << `CTRL_UPD);
    endfunction
    task automatic summarize();
        if (fail_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Clock, reset and watchdog
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #300000;
        fail_count++;
        summarize();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        avRead = 1'b0;
        avWrite = 1'b0;
        avAddress = 8'h00;
        avWriteData = 32'h0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        busRead(`OFS_PERIOD);
        checkVal(rd, 32'hfff);
        busRead(`OFS_STATUS);
        checkVal(rd, 32'h2);
        busRead(8'h30);
        checkVal(rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            busWrite(`OFS_DUTY0 + 8'(4 * i), 32'hffff_0000 | (32'h1234 << i));
        end
        for (int i = 0; i < 4; i++) begin
            busRead(`OFS_DUTY0 + 8'(4 * i));
            checkVal(rd, (32'h1234 << i) & 32'h3fff);
        end
        // Single shot with a postscale that must be ignored
        busWrite(`OFS_PERIOD, 32'h5);
        busWrite(`OFS_IRQEN, 32'h1);
        busWrite(`OFS_CTRL, ctrlWord(`MODE_SINGLE, `PS_ONE, 4'h3, 1'b0, 1'b0));
        waitSig(1'b1, 1'b1);
        checkVal(32'(irq), 32'h1);
        busRead(`OFS_STATUS);
        checkVal(rd & 32'h1, 32'h1);
        busRead(`OFS_CTRL);
        checkVal(rd & 32'h1, 32'h0);
        busRead(`OFS_COUNTER);
        checkVal(rd, 32'h0);
        clearEvents();
        busRead(`OFS_STATUS);
        checkVal(rd & 32'h1, 32'h0);
        // Masked event stays sticky and raises irq once enabled
        busWrite(`OFS_IRQEN, 32'h0);
        busWrite(`OFS_CTRL, ctrlWord(`MODE_SINGLE, `PS_ONE, 4'h0, 1'b0, 1'b0));
        rd = 32'h0;
        for (int n = 0; n < 40 && rd[0] !== 1'b1; n++) begin
            busRead(`OFS_STATUS);
        end
        checkVal(rd & 32'h1, 32'h1);
        checkVal(32'(irq), 32'h0);
        busWrite(`OFS_IRQEN, 32'h1);
        waitSig(1'b1, 1'b1);
        checkVal(32'(irq), 32'h1);
        clearEvents();
        // Up/down: every zero turn, then every second one
        busWrite(`OFS_PERIOD, 32'h2);
        busWrite(`OFS_CTRL, ctrlWord(`MODE_UPDOWN, `PS_ONE, 4'h0, 1'b0, 1'b0));
        irqSpacing(d1);
        checkVal(32'(d1), 32'h10);
        checkVal(32'(irq), 32'h1);
        busWrite(`OFS_CTRL, ctrlWord(`MODE_UPDOWN, `PS_ONE, 4'h1, 1'b0, 1'b0));
        irqSpacing(d2);
        checkVal(32'(d2), 32'(2 * d1));
        busWrite(`OFS_IRQEN, 32'h0);
        clearEvents();
        // Duty width against quarter phase and prescale
        busWrite(`OFS_PERIOD, 32'h7);
        for (int p = 0; p < 2; p++) begin
            busWrite(`OFS_CTRL, ctrlWord(`MODE_FREE, 2'(p), 4'h0, 1'b0, 1'b1));
            for (int d = 0; d < 4; d++) begin
                busWrite(`OFS_DUTY0, 32'(12 + d));
                measure(w[p][d]);
                checkVal(32'(w[p][d] - w[p][0]), p ? 32'h0 : 32'(d));
            end
            checkVal(32'(w[p][0]), p ? 32'h18 : 32'hc);
        end
        // Holding copy must not reach the compare without update
        busWrite(`OFS_CTRL, ctrlWord(`MODE_FREE, `PS_ONE, 4'h0, 1'b0, 1'b0));
        measure(wa);
        busWrite(`OFS_DUTY0, 32'hc);
        measure(wb);
        checkVal(32'(wb), 32'(wa));
        busWrite(`OFS_CTRL, ctrlWord(`MODE_FREE, `PS_ONE, 4'h0, 1'b0, 1'b1));
        measure(wc);
        checkVal(32'(wc), 32'(wa - 3));
        // Complementary pair outputs
        busWrite(`OFS_CTRL, ctrlWord(`MODE_FREE, `PS_ONE, 4'h0, 1'b1, 1'b1));
        measure(wa);
        s0 = shootCount;
        repeat (40) begin
            @(posedge clk_sys);
            checkVal({28'h0, pwmLo}, {28'h0, ~pwmHi});
        end
        checkVal(32'(shootCount), 32'(s0));
        busWrite(`OFS_OVR, 32'h11);
        repeat (2) @(posedge clk_sys);
        checkVal({30'h0, pwmLo[0], pwmHi[0]}, 32'h1);
        busWrite(`OFS_OVR, 32'h10);
        repeat (2) @(posedge clk_sys);
        checkVal({30'h0, pwmLo[0], pwmHi[0]}, 32'h2);
        summarize();
    end
endmodule // pwm_timebase_irq_duty_match_bench
`default_nettype wire
